// File: pta_pkg.sv
// How it works
// - Three functions, each with four windows.
// - Window one decodes control registers by offset.
// - Direct control access uses memory-type requests.
// - Window two: 24-bit memory; three: 16-bit.
// - Lower half first core, upper half second.
// - Each memory word takes one core cycle.
// - Host never issues byte accesses to memory.
// - Window four takes I/O requests for everything.
// - Indirect registers: address with direction, data.
// - All I/O transfers are 16 bits.
// - Memory indirect set: width select, direction.
// - Memory data 24 bits; 16-bit in low bits.
// - 32-bit link acting as bus target.
// - Control registers shared by host and cores.
// - Cores write config subset until ready.
// - Cores take register bus lock, see status.
package pta_pkg;

	// ----------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------
	localparam int unsigned AW            = 24;
	localparam int unsigned DW            = 32;
	localparam int unsigned RAW           = 15;
	localparam int unsigned RDW           = 16;
	localparam int unsigned MDW           = 24;
	localparam int unsigned FUNCS         = 3;
	localparam int unsigned MEM_HALF_BIT  = 17;

	typedef enum logic [1:0] {PTA_CFG, PTA_MEM, PTA_IO} pta_kind_type;

	// ----------------------------------------------------------
	// Windows, lanes and indirect register layout
	// ----------------------------------------------------------
	localparam logic [1:0] BAR_CTRL     = 2'h0;
	localparam logic [1:0] BAR_MEM24    = 2'h1;
	localparam logic [1:0] BAR_MEM16    = 2'h2;
	localparam logic [1:0] BAR_IO       = 2'h3;
	localparam logic [3:0] BE_FULL      = 4'hf;
	localparam logic [3:0] BE_IO        = 4'h3;
	localparam logic [2:0] IO_REG_ADDR  = 3'h0;
	localparam logic [2:0] IO_REG_DATA  = 3'h1;
	localparam logic [2:0] IO_MEM_ALO   = 3'h2;
	localparam logic [2:0] IO_MEM_CTRL  = 3'h3;
	localparam logic [2:0] IO_MEM_DLO   = 3'h4;
	localparam logic [2:0] IO_MEM_DHI   = 3'h5;
	localparam int unsigned IO_RW_BIT   = 15;
	localparam int unsigned MC_WIDE_BIT = 8;
	localparam int unsigned MC_WR_BIT   = 9;
	localparam int unsigned MC_CORE_BIT = 10;
	localparam logic [15:0] IO_RST      = 16'h0000;

	// ----------------------------------------------------------
	// Configuration words
	// ----------------------------------------------------------
	localparam logic [1:0]  CFG_ID        = 2'h0;
	localparam logic [1:0]  CFG_CMD       = 2'h1;
	localparam logic [1:0]  CFG_SUB       = 2'h2;
	localparam logic [1:0]  CFG_CTL       = 2'h3;
	localparam int unsigned CFG_READY_BIT = 7;
	localparam logic [7:0]  CFG_CTL_RST   = 8'h02;
	localparam logic [31:0] CFG_WORD_RST  = 32'h0000_0000;

	// ----------------------------------------------------------
	// Timing
	// ----------------------------------------------------------
	localparam int unsigned MCLK_NS   = 100;
	localparam int unsigned LINK_NS   = 30;
	localparam int unsigned LINK_HALF =
		(LINK_NS / (2 * MCLK_NS) < 1) ? 1 : LINK_NS / (2 * MCLK_NS);

endpackage

// File: pta_link_if.sv
`timescale 1ns/1ps
interface pta_link_if;
	logic                   pclk;
	logic                   req;
	pta_pkg::pta_kind_type  kind;
	logic [1:0]             func;
	logic [1:0]             bar;
	logic [pta_pkg::AW-1:0] addr;
	logic                   we;
	logic [3:0]             be;
	logic [pta_pkg::DW-1:0] wdata;
	logic                   ack;
	logic [pta_pkg::DW-1:0] rdata;
	logic                   err;

	modport host (output pclk, req, kind, func, bar, addr, we, be, wdata,
		input ack, rdata, err);
	modport dev (input pclk, req, kind, func, bar, addr, we, be, wdata,
		output ack, rdata, err);
endinterface

// File: pta_sync2.sv
`timescale 1ns/1ps
module pta_sync2 (
	input  wire logic clk,   // destination clock
	input  wire logic rst_b, // async reset
	input  wire logic d,     // foreign level
	output logic      q      // synchronised level
);
	logic meta;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// File: pta_host_end.sv
`timescale 1ns/1ps
module pta_host_end #(
	parameter int unsigned HALF = pta_pkg::LINK_HALF
) (
	input  wire logic                   mclk,      // host clock
	input  wire logic                   rst_b,     // async reset
	pta_link_if.host                    lnk,       // link to device
	input  wire logic                   cmd_valid, // request offered
	output logic                        cmd_ready, // request taken
	input  pta_pkg::pta_kind_type       cmd_kind,  // cfg, mem or io
	input  wire logic [1:0]             cmd_func,  // function
	input  wire logic [1:0]             cmd_bar,   // window
	input  wire logic [pta_pkg::AW-1:0] cmd_addr,  // byte offset
	input  wire logic                   cmd_we,    // write
	input  wire logic [3:0]             cmd_be,    // byte lanes
	input  wire logic [pta_pkg::DW-1:0] cmd_wdata, // write data
	output logic                        rsp_valid, // answer pulse
	output logic [pta_pkg::DW-1:0]      rsp_data,  // read data
	output logic                        rsp_err    // refused
);
	typedef enum logic [1:0] {H_IDLE, H_REQ, H_REL} pta_hst_type;

	if (HALF < 1 || HALF > 256) begin : g_chk
		$error("pta_host_end: HALF out of range");
	end

	pta_hst_type h_state;
	logic [7:0]  cnt;
	logic        pclk_q;
	logic        ack_s;
	logic        bad;

	// ----------------------------------------------------------
	// Link clock divider
	// ----------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt    <= 8'h00;
			pclk_q <= 1'b0;
		end else if (cnt == 8'(HALF - 1)) begin
			cnt    <= 8'h00;
			pclk_q <= ~pclk_q;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	assign lnk.pclk = pclk_q;

	pta_sync2 u_ack (.clk(mclk), .rst_b(rst_b), .d(lnk.ack), .q(ack_s));

	// ----------------------------------------------------------
	// Request sequencing
	// ----------------------------------------------------------
	// Malformed requests are answered locally and never reach the link.
	assign bad = (cmd_kind == pta_pkg::PTA_MEM && cmd_be != pta_pkg::BE_FULL
		&& (cmd_bar == pta_pkg::BAR_MEM24
		|| cmd_bar == pta_pkg::BAR_MEM16))
		|| (cmd_kind == pta_pkg::PTA_IO && (cmd_bar != pta_pkg::BAR_IO
		|| cmd_be != pta_pkg::BE_IO))
		|| (cmd_kind == pta_pkg::PTA_MEM
		&& cmd_bar == pta_pkg::BAR_IO);
	assign cmd_ready = h_state == H_IDLE;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			h_state   <= H_IDLE;
			lnk.req   <= 1'b0;
			lnk.kind  <= pta_pkg::PTA_CFG;
			lnk.func  <= 2'h0;
			lnk.bar   <= 2'h0;
			lnk.addr  <= '0;
			lnk.we    <= 1'b0;
			lnk.be    <= 4'h0;
			lnk.wdata <= '0;
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
			rsp_err   <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (h_state)
			H_IDLE: begin
				if (cmd_valid && bad) begin
					rsp_valid <= 1'b1;
					rsp_err   <= 1'b1;
					rsp_data  <= '0;
				end else if (cmd_valid) begin
					lnk.kind  <= cmd_kind;
					lnk.func  <= cmd_func;
					lnk.bar   <= cmd_bar;
					lnk.addr  <= cmd_addr;
					lnk.we    <= cmd_we;
					lnk.be    <= cmd_be;
					lnk.wdata <= cmd_wdata;
					lnk.req   <= 1'b1;
					h_state   <= H_REQ;
				end
			end
			H_REQ: begin
				// Answer fields are held by the device while ack stands.
				if (ack_s) begin
					rsp_valid <= 1'b1;
					rsp_data  <= lnk.rdata;
					rsp_err   <= lnk.err;
					lnk.req   <= 1'b0;
					h_state   <= H_REL;
				end
			end
			H_REL: begin
				if (!ack_s) begin
					h_state <= H_IDLE;
				end
			end
			endcase
		end
	end
endmodule

// File: pta_dev_end.sv
`timescale 1ns/1ps
module pta_dev_end #(
	parameter int unsigned FUNC_COUNT = pta_pkg::FUNCS,
	parameter int unsigned HALF_BIT   = pta_pkg::MEM_HALF_BIT,
	parameter logic [31:0] ID_VALUE   = 32'h5a5a_a5a5 // arbitrary value
) (
	input  wire logic                    mclk,       // core clock
	input  wire logic                    rst_b,      // async reset
	pta_link_if.dev                      lnk,        // host link
	output logic                         rb_strobe,  // register access
	output logic                         rb_we,      // register write
	output logic [pta_pkg::RAW-1:0]      rb_addr,    // register address
	output logic [pta_pkg::RDW-1:0]      rb_wdata,   // register data
	input  wire logic [pta_pkg::RDW-1:0] rb_rdata,   // read with strobe
	input  wire logic [1:0]              core_req,   // core requests
	input  wire logic [1:0]              core_we,    // core writes
	input  wire logic [pta_pkg::RAW-1:0] core_addr [2], // core addresses
	input  wire logic [pta_pkg::RDW-1:0] core_wdata [2], // core data
	output logic [1:0]                   core_ack,   // core done pulse
	output logic [pta_pkg::RDW-1:0]      core_rdata, // core read data
	input  wire logic [1:0]              core_lock,  // lock flags
	output logic [1:0]                   lock_status, // lock held
	input  wire logic                    cfg_wr,     // core cfg write
	input  wire logic [1:0]              cfg_func,   // cfg function
	input  wire logic [1:0]              cfg_idx,    // cfg word
	input  wire logic [31:0]             cfg_wdata,  // cfg data
	output logic                         cfg_ready,  // cfg locked
	output logic                         dma_strobe, // memory word
	output logic                         dma_core,   // second core
	output logic                         dma_wide,   // 24-bit memory
	output logic                         dma_we,     // memory write
	output logic [pta_pkg::AW-1:0]       dma_addr,   // word address
	output logic [pta_pkg::MDW-1:0]      dma_wdata,  // memory data
	input  wire logic [pta_pkg::MDW-1:0] dma_rdata   // read with strobe
);
	typedef enum logic [1:0] {L_IDLE, L_WAIT, L_ACK, L_DROP} pta_lst_type;
	typedef enum logic [1:0] {C_IDLE, C_REG, C_MEM} pta_cst_type;
	typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_C0, OWN_C1}
		pta_own_type;

	if (FUNC_COUNT < 1 || FUNC_COUNT > 3 || HALF_BIT < 3
		|| HALF_BIT > pta_pkg::AW - 1) begin : g_chk
		$error("pta_dev_end: unsupported parameter");
	end

	pta_lst_type           l_state;
	pta_cst_type           c_state;
	pta_own_type           rb_own, next_own;
	pta_pkg::pta_kind_type c_kind;
	logic [1:0]            c_func, c_bar, fi, lock_own, next_lock;
	logic [23:0]           c_addr, h_addr, d_addr;
	logic [31:0]           c_wdata, res_data, d_rd;
	logic [3:0]            c_be;
	logic                  c_we, req_s, done_s, xfer, xreq_s, done;
	logic                  res_err, take, fn_ok, h_we, h_ind;
	logic                  d_err, d_reg, d_mem, d_we, d_core, d_wide;
	logic [23:0]           h_wdat, d_wdat, io_mdat;
	logic [15:0]           io_radr, io_rdat, io_malo, io_mctl, w16;
	logic [31:0]           cfg_cmd [3];
	logic [31:0]           cfg_sub [3];
	logic [7:0]            cfg_ctl;

	// ----------------------------------------------------------
	// Link side, on the link clock
	// ----------------------------------------------------------
	pta_sync2 u_req (.clk(lnk.pclk), .rst_b(rst_b), .d(lnk.req), .q(req_s));
	pta_sync2 u_done (.clk(lnk.pclk), .rst_b(rst_b), .d(done), .q(done_s));
	pta_sync2 u_xreq (.clk(mclk), .rst_b(rst_b), .d(xfer), .q(xreq_s));

	always_ff @(posedge lnk.pclk or negedge rst_b) begin
		if (!rst_b) begin
			c_kind  <= pta_pkg::PTA_CFG;
			c_func  <= 2'h0;
			c_bar   <= 2'h0;
			c_addr  <= '0;
			c_we    <= 1'b0;
			c_be    <= 4'h0;
			c_wdata <= '0;
		end else if (l_state == L_IDLE && req_s) begin
			c_kind  <= lnk.kind;
			c_func  <= lnk.func;
			c_bar   <= lnk.bar;
			c_addr  <= lnk.addr;
			c_we    <= lnk.we;
			c_be    <= lnk.be;
			c_wdata <= lnk.wdata;
		end
	end

	// Four-phase handshake: held fields are read across only while
	// xfer stands, so no word is sampled while it moves.
	always_ff @(posedge lnk.pclk or negedge rst_b) begin
		if (!rst_b) begin
			l_state   <= L_IDLE;
			xfer      <= 1'b0;
			lnk.ack   <= 1'b0;
			lnk.rdata <= '0;
			lnk.err   <= 1'b0;
		end else begin
			unique case (l_state)
			L_IDLE: if (req_s) begin
				xfer    <= 1'b1;
				l_state <= L_WAIT;
			end
			L_WAIT: if (done_s) begin
				lnk.ack   <= 1'b1;
				lnk.rdata <= res_data;
				lnk.err   <= res_err;
				xfer      <= 1'b0;
				l_state   <= L_ACK;
			end
			L_ACK: if (!req_s) begin
				lnk.ack <= 1'b0;
				l_state <= L_DROP;
			end
			L_DROP: if (!done_s) begin
				l_state <= L_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------
	// Decode, on the core clock
	// ----------------------------------------------------------
	assign take  = c_state == C_IDLE && xreq_s && !done;
	assign w16   = c_wdata[15:0];
	assign fi    = (c_func == 2'h3) ? 2'h0 : c_func;
	assign fn_ok = c_func <= cfg_ctl[1:0]
		&& 32'(c_func) < FUNC_COUNT;

	always_comb begin
		d_err  = 1'b0;
		d_rd   = '0;
		d_reg  = 1'b0;
		d_mem  = 1'b0;
		d_addr = '0;
		d_we   = c_we;
		d_wdat = '0;
		d_core = io_mctl[pta_pkg::MC_CORE_BIT];
		d_wide = io_mctl[pta_pkg::MC_WIDE_BIT];
		unique case (c_kind)
		pta_pkg::PTA_CFG: begin
			d_err = !fn_ok;
			unique case (c_addr[3:2])
			pta_pkg::CFG_ID:  d_rd = ID_VALUE;
			pta_pkg::CFG_CMD: d_rd = cfg_cmd[fi];
			pta_pkg::CFG_SUB: d_rd = cfg_sub[fi];
			pta_pkg::CFG_CTL: d_rd = 32'(cfg_ctl);
			endcase
		end
		pta_pkg::PTA_MEM: begin
			if (!fn_ok || c_bar == pta_pkg::BAR_IO) begin
				d_err = 1'b1;
			end else if (c_bar == pta_pkg::BAR_CTRL) begin
				d_reg  = 1'b1;
				d_addr = 24'(c_addr[15:1]);
				d_wdat = 24'(w16);
			end else if (c_be != pta_pkg::BE_FULL) begin
				d_err = 1'b1;
			end else begin
				d_mem  = 1'b1;
				d_wide = c_bar == pta_pkg::BAR_MEM24;
				d_core = c_addr[HALF_BIT];
				d_addr = 24'(c_addr[HALF_BIT-1:2]);
				d_wdat = d_wide ? c_wdata[23:0] : 24'(w16);
			end
		end
		pta_pkg::PTA_IO: begin
			if (!fn_ok || c_bar != pta_pkg::BAR_IO
				|| c_be != pta_pkg::BE_IO) begin
				d_err = 1'b1;
			end else begin
				unique case (c_addr[3:1])
				pta_pkg::IO_REG_ADDR: begin
					d_rd   = 32'(io_radr);
					d_reg  = c_we && !w16[pta_pkg::IO_RW_BIT];
					d_we   = 1'b0;
					d_addr = 24'(w16[14:0]);
				end
				pta_pkg::IO_REG_DATA: begin
					d_rd   = 32'(io_rdat);
					d_reg  = c_we && io_radr[pta_pkg::IO_RW_BIT];
					d_addr = 24'(io_radr[14:0]);
					d_wdat = 24'(w16);
				end
				pta_pkg::IO_MEM_ALO: d_rd = 32'(io_malo);
				pta_pkg::IO_MEM_CTRL: begin
					d_rd   = 32'(io_mctl);
					d_mem  = c_we && !w16[pta_pkg::MC_WR_BIT];
					d_we   = 1'b0;
					d_addr = {w16[7:0], io_malo};
					d_core = w16[pta_pkg::MC_CORE_BIT];
					d_wide = w16[pta_pkg::MC_WIDE_BIT];
				end
				pta_pkg::IO_MEM_DLO: begin
					d_rd   = 32'(io_mdat[15:0]);
					d_mem  = c_we && io_mctl[pta_pkg::MC_WR_BIT]
						&& !io_mctl[pta_pkg::MC_WIDE_BIT];
					d_addr = {io_mctl[7:0], io_malo};
					d_wdat = 24'(w16);
				end
				pta_pkg::IO_MEM_DHI: begin
					d_rd   = 32'(io_mdat[23:16]);
					d_mem  = c_we && io_mctl[pta_pkg::MC_WR_BIT]
						&& io_mctl[pta_pkg::MC_WIDE_BIT];
					d_addr = {io_mctl[7:0], io_malo};
					d_wdat = {w16[7:0], io_mdat[15:0]};
				end
				default: d_err = 1'b1;
				endcase
			end
		end
		default: d_err = 1'b1;
		endcase
	end

	// ----------------------------------------------------------
	// Host access sequencing
	// ----------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			c_state  <= C_IDLE;
			done     <= 1'b0;
			res_data <= '0;
			res_err  <= 1'b0;
			h_addr   <= '0;
			h_we     <= 1'b0;
			h_wdat   <= '0;
			h_ind    <= 1'b0;
		end else begin
			unique case (c_state)
			C_IDLE: begin
				if (!xreq_s) begin
					done <= 1'b0;
				end else if (!done) begin
					res_err  <= d_err;
					res_data <= d_err ? 32'h0 : d_rd;
					h_addr   <= d_addr;
					h_we     <= d_we;
					h_wdat   <= d_wdat;
					h_ind    <= c_kind == pta_pkg::PTA_IO;
					if (d_reg && !d_err) begin
						c_state <= C_REG;
					end else if (d_mem && !d_err) begin
						c_state <= C_MEM;
					end else begin
						done <= 1'b1;
					end
				end
			end
			C_REG: if (rb_strobe && rb_own == OWN_HOST) begin
				if (!h_we && !h_ind) begin
					res_data <= 32'(rb_rdata);
				end
				done    <= 1'b1;
				c_state <= C_IDLE;
			end
			C_MEM: begin
				// Narrow memory leaves its upper byte undefined; drop it.
				if (!h_we && !h_ind) begin
					res_data <= dma_wide ? 32'(dma_rdata)
						: 32'(dma_rdata[15:0]);
				end
				done    <= 1'b1;
				c_state <= C_IDLE;
			end
			default: c_state <= C_IDLE;
			endcase
		end
	end

	// The memory path gets exactly one strobe, one core cycle, per word.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dma_strobe <= 1'b0;
			dma_core   <= 1'b0;
			dma_wide   <= 1'b0;
			dma_we     <= 1'b0;
			dma_addr   <= '0;
			dma_wdata  <= '0;
		end else begin
			dma_strobe <= take && d_mem && !d_err;
			if (take && d_mem) begin
				dma_core  <= d_core;
				dma_wide  <= d_wide;
				dma_we    <= d_we;
				dma_addr  <= d_addr;
				dma_wdata <= d_wdat;
			end
		end
	end

	// ----------------------------------------------------------
	// Indirect registers
	// ----------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			io_radr <= pta_pkg::IO_RST;
			io_rdat <= pta_pkg::IO_RST;
			io_malo <= pta_pkg::IO_RST;
			io_mctl <= pta_pkg::IO_RST;
			io_mdat <= '0;
		end else if (take && c_kind == pta_pkg::PTA_IO && !d_err && c_we) begin
			case (c_addr[3:1])
			pta_pkg::IO_REG_ADDR: io_radr <= w16;
			pta_pkg::IO_REG_DATA: io_rdat <= w16;
			pta_pkg::IO_MEM_ALO:  io_malo <= w16;
			pta_pkg::IO_MEM_CTRL: io_mctl <= w16;
			pta_pkg::IO_MEM_DLO:  io_mdat[15:0] <= w16;
			pta_pkg::IO_MEM_DHI:  io_mdat[23:16] <= w16[7:0];
			default: ;
			endcase
		end else if (c_state == C_REG && rb_strobe && rb_own == OWN_HOST
			&& h_ind && !h_we) begin
			io_rdat <= rb_rdata;
		end else if (c_state == C_MEM && h_ind && !h_we) begin
			io_mdat <= dma_wide ? dma_rdata
				: {8'h00, dma_rdata[15:0]};
		end
	end

	// ----------------------------------------------------------
	// Configuration words
	// ----------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ctl <= pta_pkg::CFG_CTL_RST;
			for (int i = 0; i < 3; i++) begin
				cfg_sub[i] <= pta_pkg::CFG_WORD_RST;
			end
		end else if (cfg_wr && !cfg_ctl[pta_pkg::CFG_READY_BIT]) begin
			if (cfg_idx == pta_pkg::CFG_CTL) begin
				cfg_ctl <= cfg_wdata[7:0];
			end else if (cfg_idx == pta_pkg::CFG_SUB && cfg_func != 2'h3) begin
				cfg_sub[cfg_func] <= cfg_wdata;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 3; i++) begin
				cfg_cmd[i] <= pta_pkg::CFG_WORD_RST;
			end
		end else if (take && c_kind == pta_pkg::PTA_CFG && !d_err && c_we
			&& c_addr[3:2] == pta_pkg::CFG_CMD) begin
			cfg_cmd[fi] <= c_wdata;
		end
	end
	assign cfg_ready = cfg_ctl[pta_pkg::CFG_READY_BIT];

	// ----------------------------------------------------------
	// Shared register bus: lock and arbitration
	// ----------------------------------------------------------
	always_comb begin
		next_lock = lock_own & core_lock;
		if (next_lock == 2'b00 && core_lock[0]) begin
			next_lock = 2'b01;
		end else if (next_lock == 2'b00 && core_lock[1]) begin
			next_lock = 2'b10;
		end
	end

	// No grant while an answer is still out, so a held request is
	// never served twice.
	always_comb begin
		next_own = OWN_NONE;
		if (!rb_strobe && core_ack == 2'b00) begin
			if (c_state == C_REG && lock_own == 2'b00) begin
				next_own = OWN_HOST;
			end else if (core_req[0] && !lock_own[1]) begin
				next_own = OWN_C0;
			end else if (core_req[1] && !lock_own[0]) begin
				next_own = OWN_C1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lock_own  <= 2'b00;
			rb_own    <= OWN_NONE;
			rb_strobe <= 1'b0;
			rb_we     <= 1'b0;
			rb_addr   <= '0;
			rb_wdata  <= '0;
		end else begin
			lock_own  <= next_lock;
			rb_own    <= next_own;
			rb_strobe <= next_own != OWN_NONE;
			unique case (next_own)
			OWN_HOST: begin
				rb_we    <= h_we;
				rb_addr  <= h_addr[14:0];
				rb_wdata <= h_wdat[15:0];
			end
			OWN_C0: begin
				rb_we    <= core_we[0];
				rb_addr  <= core_addr[0];
				rb_wdata <= core_wdata[0];
			end
			OWN_C1: begin
				rb_we    <= core_we[1];
				rb_addr  <= core_addr[1];
				rb_wdata <= core_wdata[1];
			end
			OWN_NONE: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			core_ack   <= 2'b00;
			core_rdata <= '0;
		end else begin
			core_ack[0] <= rb_strobe && rb_own == OWN_C0;
			core_ack[1] <= rb_strobe && rb_own == OWN_C1;
			if (rb_strobe) begin
				core_rdata <= rb_rdata;
			end
		end
	end
	assign lock_status = lock_own;
endmodule

// File: pta_link_asserts.sv
`timescale 1ns/1ps
module pta_link_asserts (
	input wire logic             pclk,  // link clock
	input wire logic             rst_b, // async reset
	input wire logic             req,   // host request
	input pta_pkg::pta_kind_type kind,  // request kind
	input wire logic [1:0]       bar,   // window
	input wire logic [3:0]       be,    // byte lanes
	input wire logic [23:0]      addr,  // offset
	input wire logic [31:0]      wdata, // write data
	input wire logic             ack,   // device answer
	input wire logic [31:0]      rdata, // read data
	input wire logic             err    // refused
);
	// ------------------------------------------------------------
	// Handshake checks
	// ------------------------------------------------------------
	// Both ends are sampled on the link clock, where the device acts.
	default clocking @(posedge pclk); endclocking
	default disable iff (!rst_b);
	a_req_hold: assert property (req && !ack |=> req)
		else $error("request dropped before answer");
	a_fields_stable: assert property (req && $past(req) |->
		$stable({kind, bar, be, addr, wdata}))
		else $error("request fields moved");
	a_ack_cause: assert property ($rose(ack) |-> req)
		else $error("answer without request");
	a_ack_release: assert property ($fell(req) |-> ##[1:4] !ack)
		else $error("answer not released");
	a_rsp_stable: assert property (ack && $past(ack) |->
		$stable(rdata) && $stable(err))
		else $error("answer moved");
	a_io_width: assert property (req && kind == pta_pkg::PTA_IO |->
		be == 4'h3 && bar == 2'h3)
		else $error("wide or misrouted io");
	a_mem_words: assert property (req && kind == pta_pkg::PTA_MEM |->
		(be == 4'hf || bar == 2'h0) && bar != 2'h3)
		else $error("byte memory access");
	a_err_zero: assert property (ack && err |-> rdata == 32'h0)
		else $error("refusal carries data");
	cover property (ack && !err && kind == pta_pkg::PTA_MEM);
	cover property (ack && kind == pta_pkg::PTA_IO);
	cover property (ack && err);
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected %0t mismatch %h %h", $time, a, b); end end
module tb_top;
	localparam pta_pkg::pta_kind_type mk = pta_pkg::PTA_MEM;
	localparam pta_pkg::pta_kind_type ik = pta_pkg::PTA_IO;
	localparam pta_pkg::pta_kind_type ck = pta_pkg::PTA_CFG;
	logic mclk = 0, rst_b = 0, cmd_valid = 0, cmd_we = 0, cfg_wr = 0;
	logic cmd_ready, rsp_valid, rsp_err, rb_strobe, rb_we, dma_strobe;
	logic dma_core, dma_wide, dma_we, cfg_ready;
	logic [31:0] cfg_wdata = 0;
	pta_pkg::pta_kind_type cmd_kind = ck;
	logic [1:0] cmd_func = 0, cmd_bar = 0, core_req = 0, core_we = 0;
	logic [1:0] core_lock = 0, core_ack, lock_status, last_dma, cfg_idx = 0;
	logic [3:0] cmd_be = 0;
	logic [23:0] cmd_addr = 0, dma_addr, dma_wdata;
	logic [31:0] cmd_wdata = 0, rsp_data, last_rb, rnd = 32'h9cafc123;
	logic [14:0] rb_addr, core_addr [2] = '{15'h0123, 15'h0};
	logic [15:0] rb_wdata, core_rdata, core_wdata [2] = '{16'hbeef, 16'h0};
	logic [33:0] q [$], e;
	wire [15:0] rb_rdata = {1'b1, rb_addr} ^ 16'h5a5a;
	wire [23:0] dma_rdata = dma_addr ^ 24'h5aa5a5;
	int num_errors = 0, compares = 0, nrsp = 0, sent = 0;
	pta_link_if lnk();
	pta_host_end #(.HALF(1)) pta_host_end_i (.mclk, .rst_b, .lnk(lnk),
		.cmd_valid, .cmd_ready, .cmd_kind, .cmd_func, .cmd_bar, .cmd_addr,
		.cmd_we, .cmd_be, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_err);
	pta_dev_end pta_dev_end_i (.mclk, .rst_b, .lnk(lnk), .rb_strobe, .rb_we,
		.rb_addr, .rb_wdata, .rb_rdata, .core_req, .core_we, .core_addr,
		.core_wdata, .core_ack, .core_rdata, .core_lock, .lock_status,
		.cfg_wr, .cfg_func(2'h0), .cfg_idx, .cfg_wdata,
		.cfg_ready, .dma_strobe, .dma_core, .dma_wide, .dma_we, .dma_addr,
		.dma_wdata, .dma_rdata);
	pta_link_asserts pta_link_asserts_i (.pclk(lnk.pclk), .rst_b,
		.req(lnk.req), .kind(lnk.kind), .bar(lnk.bar), .be(lnk.be),
		.addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
		.rdata(lnk.rdata), .err(lnk.err));
	initial forever #50 mclk = ~mclk;
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	always @(posedge mclk) begin
		if (rb_strobe) last_rb = {rb_we, rb_addr, rb_wdata};
		if (dma_strobe) last_dma = {dma_core, dma_wide};
		if (rsp_valid) begin
			e = q.pop_front();
			`CHK(rsp_err, e[32])
			if (e[33]) `CHK(rsp_data, e[31:0])
			nrsp++;
		end
	end
	// Expectation: {check data, error, data}.
	task cmd(pta_pkg::pta_kind_type k, logic [1:0] b, logic [23:0] a,
		logic w, logic [3:0] m, logic [31:0] d, logic [33:0] x);
		@(negedge mclk);
		for (int i = 0; i < 99 && cmd_ready !== 1; i++) @(negedge mclk);
		{cmd_kind, cmd_bar, cmd_addr, cmd_we, cmd_be} = {k, b, a, w, m};
		cmd_wdata = d;
		cmd_valid = 1;
		q.push_back(x);
		sent++;
		@(negedge mclk);
		cmd_valid = 0;
		for (int i = 0; i < 999 && nrsp < sent; i++) @(negedge mclk);
	endtask
	task test_done;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#5000000 num_errors++;
		test_done;
	end
	initial begin
		repeat (16) @(negedge mclk);
		rst_b = 1;
		for (int i = 0; i < 6; i++) begin
			rnd = xs(rnd);
			cmd(mk, 0, {rnd[15:1], 1'b0}, 0, 4'hf, 0,
				{18'h20000, {1'b1, rnd[15:1]} ^ 16'h5a5a});
		end
		cmd(mk, 0, 24'h40, 1, 4'hf, 32'h1234, 0);
		`CHK(last_rb, {1'b1, 15'h20, 16'h1234})
		cmd(mk, 1, 24'h100, 0, 4'hf, 0, {10'h200, 24'h40 ^ 24'h5aa5a5});
		`CHK(last_dma, 2'b01)
		cmd(mk, 2, 24'h20008, 0, 4'hf, 0, {18'h20000, 16'h2 ^ 16'ha5a5});
		`CHK(last_dma, 2'b10)
		cmd(mk, 1, 24'h10, 1, 4'hf, 32'habcdef, 0);
		`CHK({dma_we, dma_wdata}, {1'b1, 24'habcdef})
		cmd(mk, 1, 24'h4, 0, 4'h1, 0, {2'b11, 32'h0});
		cmd(ik, 3, 24'h0, 1, 4'hf, 0, {2'b11, 32'h0});
		cmd(mk, 3, 24'h0, 0, 4'hf, 0, {2'b11, 32'h0});
		cmd(ik, 3, 24'h0, 1, 4'h3, 32'h8021, 0);
		cmd(ik, 3, 24'h2, 1, 4'h3, 32'hcafe, 0);
		`CHK(last_rb, {1'b1, 15'h21, 16'hcafe})
		cmd(ik, 3, 24'h0, 1, 4'h3, 32'h21, 0);
		cmd(ik, 3, 24'h2, 0, 4'h3, 0, {18'h20000, 16'h8021 ^ 16'h5a5a});
		cmd(ik, 3, 24'h4, 1, 4'h3, 32'h5, 0);
		cmd(ik, 3, 24'h6, 1, 4'h3, 32'h512, 0);
		`CHK(last_dma, 2'b11)
		cmd(ik, 3, 24'h8, 0, 4'h3, 0, {18'h20000, 16'ha5a0});
		cmd(ik, 3, 24'ha, 0, 4'h3, 0, {26'h2000000, 8'h48});
		cmd(ik, 3, 24'h6, 1, 4'h3, 32'h12, 0);
		cmd(ik, 3, 24'ha, 0, 4'h3, 0, {2'b10, 32'h0});
		cmd_func = 2;
		cmd(ck, 0, 24'h0, 0, 4'hf, 0, {2'b10, 32'h5a5aa5a5});
		{cfg_wr, cfg_idx, cfg_wdata} = {1'b1, 2'h3, 32'h81};
		@(negedge mclk);
		cfg_wdata = 32'h2;
		@(negedge mclk);
		cfg_wr = 0;
		`CHK(cfg_ready, 1'b1)
		cmd(ck, 0, 24'h4, 0, 4'hf, 0, {2'b11, 32'h0});
		cmd_func = 3;
		cmd(ck, 0, 24'h0, 0, 4'hf, 0, {2'b11, 32'h0});
		core_lock = 2'b01;
		repeat (2) @(negedge mclk);
		`CHK(lock_status, 2'b01)
		{core_req, core_we} = 4'h5;
		for (int i = 0; i < 20 && core_ack[0] !== 1; i++) @(negedge mclk);
		{core_req, core_lock} = 4'h0;
		`CHK(last_rb, {1'b1, 15'h123, 16'hbeef})
		`CHK(core_rdata, 16'h8123 ^ 16'h5a5a)
		`CHK(nrsp, sent)
		test_done;
	end
endmodule
